// >>> verilog/rpi_params.svh
// register offsets, field positions and reset values for the receive port interrupt logic
`ifndef RPI_PARAMS_SVH
`define RPI_PARAMS_SVH

`define RPI_ADDR_EN_HI 8'hd8
`define RPI_ADDR_EN_LO 8'hd9
`define RPI_ADDR_ST_HI 8'hda
`define RPI_ADDR_ST_LO 8'hdb
`define RPI_ADDR_GPIO_ST 8'hdc
`define RPI_ADDR_GPIO_EN 8'hdd

`define RPI_RST_BYTE 8'h00
`define RPI_EN_HI_MASK 8'h07
`define RPI_HI_W 5
`define RPI_LO_W 7

`define RPI_LO_LOCK 0
`define RPI_LO_VALID 1
`define RPI_LO_PARITY 2
`define RPI_LO_CAMERA 3
`define RPI_LO_OVERFLOW 4
`define RPI_LO_LINE_CNT 5
`define RPI_LO_LINE_LEN 6

`define RPI_HI_CRC 0
`define RPI_HI_SEQ 1
`define RPI_HI_ENC 2
`define RPI_HI_SENSOR 3
`define RPI_HI_GPIO 4

`define RPI_NUM_GPIO 4

`endif

// >>> verilog/rpi_pkg.sv
// shared types of the receive port interrupt logic
`default_nettype none
package rpi_pkg;
	typedef logic [7:0] rpi_byte_t;
	typedef logic [3:0] rpi_gpio_t;
endpackage
`default_nettype wire

// >>> verilog/rpi_gpio_if.sv
// carrier between the interrupt logic and its gpio edge unit
`timescale 1ns/100ps
`default_nettype none
interface rpi_gpio_if;
	import rpi_pkg::*;
	rpi_gpio_t gpio_raw;
	rpi_gpio_t rise_en;
	rpi_gpio_t fall_en;
	logic flags_clear;
	rpi_gpio_t live_values;
	rpi_gpio_t event_flags;
	logic edge_event;
	modport ctrl (output gpio_raw, output rise_en, output fall_en, output flags_clear,
		input live_values, input event_flags, input edge_event);
	modport unit (input gpio_raw, input rise_en, input fall_en, input flags_clear,
		output live_values, output event_flags, output edge_event);
endinterface
`default_nettype wire

// >>> verilog/rpi_gpio_edge.sv
// forward gpio synchroniser, edge detector and clear-on-read edge flags
`timescale 1ns/100ps
`default_nettype none
`include "rpi_params.svh"
module rpi_gpio_edge #(
	parameter int NUM_GPIO = `RPI_NUM_GPIO
) (
	input wire logic core_clk,
	input wire logic rst_n,
	rpi_gpio_if.unit gp
);
	import rpi_pkg::*;

	generate
		if (NUM_GPIO != `RPI_NUM_GPIO) begin : g_bad_width
			$error("rpi_gpio_edge supports only four gpio lines");
		end
	endgenerate

	logic [NUM_GPIO-1:0] sync1_q, sync2_q, prev_q, flags_q, evt_q;
	logic armed_q;
	wire logic [NUM_GPIO-1:0] hit;

	genvar i;
	generate
		for (i = 0; i < NUM_GPIO; i++) begin : g_edge
			// enabled rise or fall, ignored until the first sample after reset is in
			assign hit[i] = armed_q & ((gp.rise_en[i] & sync2_q[i] & ~prev_q[i])
				| (gp.fall_en[i] & ~sync2_q[i] & prev_q[i]));
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
			armed_q <= 1'b0;
		end else begin
			sync1_q <= gp.gpio_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			armed_q <= 1'b1;
		end
	end

	// new edge beats a read in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
			evt_q <= '0;
		end else begin
			flags_q <= hit | (flags_q & ~{NUM_GPIO{gp.flags_clear}});
			evt_q <= hit;
		end
	end

	assign gp.live_values = sync2_q;
	assign gp.event_flags = flags_q;
	assign gp.edge_event = |evt_q;

	gpio_flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		|hit |=> |(flags_q & $past(hit))) else $error("gpio edge did not set its flag");
	gpio_flag_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		gp.flags_clear && !(|hit) |=> flags_q == '0) else $error("gpio flags not cleared on read");
endmodule // rpi_gpio_edge
`default_nettype wire

// >>> verilog/rpi_port_irq.sv
// per receive port interrupt enables, sticky status and interrupt output
`timescale 1ns/100ps
`default_nettype none
`include "rpi_params.svh"
// How it works
// - line length change raises interrupt when enabled
// - line count change raises interrupt when enabled
// - buffer overflow raises interrupt when enabled
// - camera receiver error raises interrupt when enabled
// - link parity error raises interrupt when enabled
// - port valid change either way interrupts when enabled
// - lock gained or lost interrupts when enabled
// - gpio change flag, cleared reading gpio status
// - sensor flag cleared after both sensor reads
// - encoding error flag, cleared by second status read
// - sequence error flag, cleared by first status read
// - checksum error flag, cleared by first status read
// - line length/count flags cleared by second read
// - overflow flag cleared by second status read
// - camera error flag cleared by camera status read
// - parity flag cleared by first status read
// - valid change flag cleared by first read
// - lock change flag cleared by first read
// - per gpio edge flags, clear on read
// - live gpio values, read together with the clear-on-read edge flags
// - high enables gate encoding, sequence, checksum errors
// - per gpio rise and fall edge enables
module rpi_port_irq (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire rpi_pkg::rpi_byte_t reg_wdata,
	output rpi_pkg::rpi_byte_t reg_rdata,
	input wire logic line_length_change_evt,
	input wire logic line_count_change_evt,
	input wire logic buffer_overflow_evt,
	input wire logic camera_rx_error_evt,
	input wire logic link_parity_error_evt,
	input wire logic port_valid_level,
	input wire logic lock_level,
	input wire logic link_encoding_error_evt,
	input wire logic ctrl_channel_sequence_error_evt,
	input wire logic ctrl_channel_checksum_error_evt,
	input wire logic sensor_state_change_evt,
	input wire logic receive_status_first_read,
	input wire logic receive_status_second_read,
	input wire logic camera_rx_error_status_read,
	input wire logic sensor_rise_status_read,
	input wire logic sensor_fall_status_read,
	input wire rpi_pkg::rpi_gpio_t fwd_gpio_pins,
	output logic port_irq
);
	import rpi_pkg::*;

	// sticky bit: a fresh event wins over a clear in the same cycle
	function automatic logic sticky(input logic q, input logic set, input logic clr);
		sticky = set | (q & ~clr);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic en);
		hit = en && (a == target);
	endfunction

	rpi_byte_t en_hi_q, en_lo_q, gpio_en_q, rdata_q;
	logic [`RPI_HI_W-1:0] st_hi_q, st_hi_d, hi_set, hi_clr;
	logic [`RPI_LO_W-1:0] st_lo_q, st_lo_d, lo_set, lo_clr;
	logic lock_prev_q, valid_prev_q, armed_q, irq_q;
	logic rise_seen_q, fall_seen_q;

	rpi_gpio_if gif ();

	rpi_gpio_edge #(.NUM_GPIO(`RPI_NUM_GPIO)) u_gpio (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.gp(gif.unit)
	);

	wire logic wr_en_hi = hit(reg_addr, `RPI_ADDR_EN_HI, reg_wr_en);
	wire logic wr_en_lo = hit(reg_addr, `RPI_ADDR_EN_LO, reg_wr_en);
	wire logic wr_gpio_en = hit(reg_addr, `RPI_ADDR_GPIO_EN, reg_wr_en);
	wire logic rd_gpio_st = hit(reg_addr, `RPI_ADDR_GPIO_ST, reg_rd_en);

	assign gif.gpio_raw = fwd_gpio_pins;
	assign gif.rise_en = {gpio_en_q[6], gpio_en_q[4], gpio_en_q[2], gpio_en_q[0]};
	assign gif.fall_en = {gpio_en_q[7], gpio_en_q[5], gpio_en_q[3], gpio_en_q[1]};
	assign gif.flags_clear = rd_gpio_st;

	// level change detectors, armed one cycle after reset release
	wire logic lock_change = armed_q & (lock_level ^ lock_prev_q);
	wire logic valid_change = armed_q & (port_valid_level ^ valid_prev_q);

	// sensor flag clears once both sensor status registers were read
	wire logic rise_done = rise_seen_q | sensor_rise_status_read;
	wire logic fall_done = fall_seen_q | sensor_fall_status_read;
	wire logic sensor_clear = st_hi_q[`RPI_HI_SENSOR] & rise_done & fall_done;

	always_comb begin
		lo_set = '0;
		lo_set[`RPI_LO_LINE_LEN] = line_length_change_evt;
		lo_set[`RPI_LO_LINE_CNT] = line_count_change_evt;
		lo_set[`RPI_LO_OVERFLOW] = buffer_overflow_evt;
		lo_set[`RPI_LO_CAMERA] = camera_rx_error_evt;
		lo_set[`RPI_LO_PARITY] = link_parity_error_evt;
		lo_set[`RPI_LO_VALID] = valid_change;
		lo_set[`RPI_LO_LOCK] = lock_change;
		lo_clr = '0;
		lo_clr[`RPI_LO_LINE_LEN] = receive_status_second_read;
		lo_clr[`RPI_LO_LINE_CNT] = receive_status_second_read;
		lo_clr[`RPI_LO_OVERFLOW] = receive_status_second_read;
		lo_clr[`RPI_LO_CAMERA] = camera_rx_error_status_read;
		lo_clr[`RPI_LO_PARITY] = receive_status_first_read;
		lo_clr[`RPI_LO_VALID] = receive_status_first_read;
		lo_clr[`RPI_LO_LOCK] = receive_status_first_read;
		hi_set = '0;
		hi_set[`RPI_HI_GPIO] = gif.edge_event;
		hi_set[`RPI_HI_SENSOR] = sensor_state_change_evt;
		hi_set[`RPI_HI_ENC] = link_encoding_error_evt;
		hi_set[`RPI_HI_SEQ] = ctrl_channel_sequence_error_evt;
		hi_set[`RPI_HI_CRC] = ctrl_channel_checksum_error_evt;
		hi_clr = '0;
		hi_clr[`RPI_HI_GPIO] = rd_gpio_st;
		hi_clr[`RPI_HI_SENSOR] = sensor_clear;
		hi_clr[`RPI_HI_ENC] = receive_status_second_read;
		hi_clr[`RPI_HI_SEQ] = receive_status_first_read;
		hi_clr[`RPI_HI_CRC] = receive_status_first_read;
		for (int i = 0; i < `RPI_LO_W; i++) begin
			st_lo_d[i] = sticky(st_lo_q[i], lo_set[i], lo_clr[i]);
		end
		for (int i = 0; i < `RPI_HI_W; i++) begin
			st_hi_d[i] = sticky(st_hi_q[i], hi_set[i], hi_clr[i]);
		end
	end

	// gpio and sensor flags have no enable bit here (only gpio has edge enables), so they always reach the output
	wire logic [`RPI_HI_W-1:0] hi_gate = {2'b11, en_hi_q[2:0]};
	wire logic irq_any = (|(st_lo_q & en_lo_q[`RPI_LO_W-1:0])) | (|(st_hi_q & hi_gate));

	// read mux; reserved bits and unmapped offsets return zero
	wire rpi_byte_t rd_mux =
		(reg_addr == `RPI_ADDR_EN_HI) ? (en_hi_q & `RPI_EN_HI_MASK) :
		(reg_addr == `RPI_ADDR_EN_LO) ? en_lo_q :
		(reg_addr == `RPI_ADDR_ST_HI) ? {3'h0, st_hi_q} :
		(reg_addr == `RPI_ADDR_ST_LO) ? {1'h0, st_lo_q} :
		(reg_addr == `RPI_ADDR_GPIO_ST) ? {gif.event_flags, gif.live_values} :
		(reg_addr == `RPI_ADDR_GPIO_EN) ? gpio_en_q : `RPI_RST_BYTE;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_hi_q <= `RPI_RST_BYTE;
			en_lo_q <= `RPI_RST_BYTE;
			gpio_en_q <= `RPI_RST_BYTE;
		end else begin
			if (wr_en_hi) begin
				en_hi_q <= reg_wdata & `RPI_EN_HI_MASK;
			end
			if (wr_en_lo) begin
				en_lo_q <= reg_wdata;
			end
			if (wr_gpio_en) begin
				gpio_en_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_lo_q <= '0;
			st_hi_q <= '0;
			lock_prev_q <= 1'b0;
			valid_prev_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			st_lo_q <= st_lo_d;
			st_hi_q <= st_hi_d;
			lock_prev_q <= lock_level;
			valid_prev_q <= port_valid_level;
			armed_q <= 1'b1;
		end
	end

	// remember which sensor read already happened while the flag stands
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_seen_q <= 1'b0;
			fall_seen_q <= 1'b0;
		end else begin
			rise_seen_q <= st_hi_q[`RPI_HI_SENSOR] & rise_done & ~sensor_clear;
			fall_seen_q <= st_hi_q[`RPI_HI_SENSOR] & fall_done & ~sensor_clear;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `RPI_RST_BYTE;
			irq_q <= 1'b0;
		end else begin
			if (reg_rd_en) begin
				rdata_q <= rd_mux;
			end
			irq_q <= irq_any;
		end
	end

	assign reg_rdata = rdata_q;
	assign port_irq = irq_q;

	sequence s_rise_first;
		st_hi_q[`RPI_HI_SENSOR] && sensor_rise_status_read && !sensor_fall_status_read && !sensor_state_change_evt;
	endsequence
	sequence s_fall_next;
		sensor_fall_status_read && !sensor_state_change_evt;
	endsequence

	irq_output_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		##1 port_irq == $past(irq_any)) else $error("interrupt output does not follow enabled status");
	lock_irq_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		lock_change && en_lo_q[`RPI_LO_LOCK] && !wr_en_lo |=> ##1 port_irq) else $error("lock change did not interrupt");
	valid_flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		armed_q && $changed(port_valid_level) |=> st_lo_q[`RPI_LO_VALID]) else $error("valid change not flagged");
	first_read_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		receive_status_first_read && !lo_set[`RPI_LO_PARITY] |=> !st_lo_q[`RPI_LO_PARITY]) else $error("parity flag kept");
	second_set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		line_length_change_evt && receive_status_second_read |=> st_lo_q[`RPI_LO_LINE_LEN]) else $error("event lost");
	camera_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		camera_rx_error_status_read && !camera_rx_error_evt |=> !st_lo_q[`RPI_LO_CAMERA]) else $error("camera flag kept");
	seq_err_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_hi_q[`RPI_HI_SEQ] && !receive_status_first_read |=> st_hi_q[`RPI_HI_SEQ]) else $error("sequence flag lost");
	sensor_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_rise_first ##1 s_fall_next |=> !st_hi_q[`RPI_HI_SENSOR]) else $error("sensor flag not cleared");
	hi_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		hit(reg_addr, `RPI_ADDR_ST_HI, reg_rd_en) |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits not zero");
	gpio_hi_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_gpio_st && !gif.edge_event |=> !st_hi_q[`RPI_HI_GPIO]) else $error("gpio change flag kept");
endmodule // rpi_port_irq
`default_nettype wire

// >>> verification/rpi_host_model.sv
// host side model driving the register port of the interrupt logic
`timescale 1ns/100ps
`default_nettype none
module rpi_host_model (
	input wire logic core_clk,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output rpi_pkg::rpi_byte_t reg_wdata,
	input wire rpi_pkg::rpi_byte_t reg_rdata
);
	import rpi_pkg::*;
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
	end
	// one-cycle write strobe, address and data held through the taking edge
	task automatic reg_write(input logic [7:0] a, input rpi_byte_t d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask
	// read data is registered, settled just after the edge that follows the strobe
	task automatic reg_read(input logic [7:0] a, output rpi_byte_t d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule // rpi_host_model
`default_nettype wire

// >>> verification/rpi_port_irq_bench.sv
// self-checking bench for the receive port interrupt logic
`timescale 1ns/100ps
`default_nettype none
`include "rpi_params.svh"
module rpi_port_irq_bench;
	import rpi_pkg::*;
	logic core_clk, rst_n, reg_wr_en, reg_rd_en, port_irq;
	logic [7:0] reg_addr;
	rpi_byte_t reg_wdata, reg_rdata;
	logic [8:0] evt;
	logic [1:0] lvl;
	logic [4:0] clr;
	rpi_gpio_t pins;
	int error_cnt, num_checks, cyc;
	// event sources: pulses 0..7, then valid level, lock level
	int src_t[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10};
	int hi_t[10] = '{0, 0, 0, 0, 0, 1, 1, 1, 0, 0};
	int bit_t[10] = '{6, 5, 4, 3, 2, 2, 1, 0, 1, 0};
	int clr_t[10] = '{1, 1, 1, 2, 0, 1, 0, 0, 0, 0};
	rpi_port_irq u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.line_length_change_evt(evt[0]), .line_count_change_evt(evt[1]), .buffer_overflow_evt(evt[2]),
		.camera_rx_error_evt(evt[3]), .link_parity_error_evt(evt[4]), .link_encoding_error_evt(evt[5]),
		.ctrl_channel_sequence_error_evt(evt[6]), .ctrl_channel_checksum_error_evt(evt[7]),
		.sensor_state_change_evt(evt[8]), .port_valid_level(lvl[0]), .lock_level(lvl[1]),
		.receive_status_first_read(clr[0]), .receive_status_second_read(clr[1]),
		.camera_rx_error_status_read(clr[2]), .sensor_rise_status_read(clr[3]),
		.sensor_fall_status_read(clr[4]), .fwd_gpio_pins(pins), .port_irq(port_irq));
	rpi_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic close_out;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			close_out;
		end
	end
	task automatic chk_byte(input rpi_byte_t exp, input rpi_byte_t got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic chk_bit(input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input rpi_byte_t exp);
		rpi_byte_t v;
		u_host.reg_read(a, v);
		chk_byte(exp, v);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic fire(input int s);
		@(posedge core_clk);
		if (s < 9) evt[s] <= 1'b1;
		else lvl[s - 9] <= ~lvl[s - 9];
		@(posedge core_clk);
		evt <= '0;
	endtask
	task automatic strobe(input int c);
		@(posedge core_clk);
		clr[c] <= 1'b1;
		@(posedge core_clk);
		clr <= '0;
	endtask
	initial begin
		logic [7:0] a, m;
		evt = '0;
		lvl = '0;
		clr = '0;
		pins = '0;
		rst_n = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		cyc = 0;
		wait_cyc(5);
		rst_n <= 1'b1;
		for (int i = 8'hd8; i <= 8'hdd; i++) rd_chk(i[7:0], 8'h00);
		rd_chk(8'h50, 8'h00);
		chk_bit(1'b0, port_irq);
		u_host.reg_write(`RPI_ADDR_EN_HI, 8'hff);
		rd_chk(`RPI_ADDR_EN_HI, 8'h07);
		u_host.reg_write(`RPI_ADDR_EN_LO, 8'hff);
		rd_chk(`RPI_ADDR_EN_LO, 8'hff);
		u_host.reg_write(`RPI_ADDR_ST_LO, 8'hff);
		rd_chk(`RPI_ADDR_ST_LO, 8'h00);
		// second pass moves the levels back, so both directions are seen
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 10; i++) begin
				a = hi_t[i] ? `RPI_ADDR_ST_HI : `RPI_ADDR_ST_LO;
				m = 8'h01 << bit_t[i];
				fire(src_t[i]);
				rd_chk(a, m);
				chk_bit(1'b1, port_irq);
				strobe((clr_t[i] + 1) % 3);
				wait_cyc(2);
				rd_chk(a, m);
				strobe(clr_t[i]);
				wait_cyc(2);
				rd_chk(a, 8'h00);
				chk_bit(1'b0, port_irq);
			end
		end
		// enables only gate the output, status still latches
		u_host.reg_write(`RPI_ADDR_EN_LO, 8'hef);
		fire(2);
		rd_chk(`RPI_ADDR_ST_LO, 8'h10);
		chk_bit(1'b0, port_irq);
		u_host.reg_write(`RPI_ADDR_EN_LO, 8'hff);
		wait_cyc(2);
		chk_bit(1'b1, port_irq);
		strobe(1);
		u_host.reg_write(`RPI_ADDR_EN_HI, 8'h00);
		fire(7);
		wait_cyc(3);
		chk_bit(1'b0, port_irq);
		strobe(0);
		u_host.reg_write(`RPI_ADDR_EN_HI, 8'h07);
		fire(8);
		rd_chk(`RPI_ADDR_ST_HI, 8'h08);
		chk_bit(1'b1, port_irq);
		strobe(3);
		wait_cyc(2);
		rd_chk(`RPI_ADDR_ST_HI, 8'h08);
		strobe(4);
		wait_cyc(2);
		rd_chk(`RPI_ADDR_ST_HI, 8'h00);
		// rise and fall reads on back-to-back cycles
		fire(8);
		@(posedge core_clk);
		clr[3] <= 1'b1;
		@(posedge core_clk);
		clr <= 5'h10;
		@(posedge core_clk);
		clr <= '0;
		wait_cyc(2);
		rd_chk(`RPI_ADDR_ST_HI, 8'h00);
		// event and its clear on one edge: the event wins
		@(posedge core_clk);
		evt[0] <= 1'b1;
		clr[1] <= 1'b1;
		@(posedge core_clk);
		evt <= '0;
		clr <= '0;
		rd_chk(`RPI_ADDR_ST_LO, 8'h40);
		strobe(1);
		wait_cyc(2);
		rd_chk(`RPI_ADDR_ST_LO, 8'h00);
		// gpio0 rise and gpio1 fall enabled only
		u_host.reg_write(`RPI_ADDR_GPIO_EN, 8'h09);
		rd_chk(`RPI_ADDR_GPIO_EN, 8'h09);
		pins <= 4'h1;
		wait_cyc(8);
		rd_chk(`RPI_ADDR_ST_HI, 8'h10);
		chk_bit(1'b1, port_irq);
		rd_chk(`RPI_ADDR_GPIO_ST, 8'h11);
		rd_chk(`RPI_ADDR_GPIO_ST, 8'h01);
		rd_chk(`RPI_ADDR_ST_HI, 8'h00);
		pins <= 4'h3;
		wait_cyc(8);
		rd_chk(`RPI_ADDR_GPIO_ST, 8'h03);
		pins <= 4'h1;
		wait_cyc(8);
		rd_chk(`RPI_ADDR_GPIO_ST, 8'h21);
		pins <= 4'h0;
		wait_cyc(8);
		rd_chk(`RPI_ADDR_GPIO_ST, 8'h00);
		rd_chk(`RPI_ADDR_ST_HI, 8'h00);
		chk_bit(1'b0, port_irq);
		close_out;
	end
endmodule // rpi_port_irq_bench
`default_nettype wire
